//--- dv/host_model.sv
// host microcontroller model: apb master that writes commands and reads results
// assumes the unit under test answers on sys_clk_i; read checks belong to the bench
`timescale 1ns/10ps
`include "mp3_host_params.svh"

module host_model (
  input  wire logic        sys_clk_i,
  input  wire logic        pready_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [11:0] paddr_o,
  output logic      [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end

  // ------------------------------------------------------------
  // one transfer, ok stays low if the slave never answers
  // ------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic ok);
    int n;
    ok = 1'b0;
    @(posedge sys_clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= {2'b00, idx, 2'b00};
    pwdata_o <= wd;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge sys_clk_i);
      ok = (pready_i === 1'b1);
    end
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released data flips so a stale value is never mistaken for a live one
    pwdata_o <= ~wd;
  endtask

  task automatic command(input logic [7:0] code, output logic ok);
    xfer(1'b1, `IDX_HOST_CMD, {24'h00_0000, code}, ok);
  endtask

  // clear first so the rewind does not wait on stale input
  task automatic fast_backward(input logic [7:0] ratio, output logic ok);
    logic a, b, c, d;
    command(`CMD_IBUF_CLR, a);
    xfer(1'b1, `IDX_PARAM_LOW, {24'h00_0000, ratio}, b);
    xfer(1'b1, `IDX_PARAM_HIGH, 32'h0000_0000, c);
    command(`CMD_FBWD, d);
    ok = a & b & c & d;
  endtask

  // rewind restart point: current sector less the rewound count
  function automatic logic [15:0] restart_sector(input logic [15:0] cur,
                                                 input logic [15:0] rew);
    return cur - rew;
  endfunction
endmodule // host_model

//--- dv/mp3_host_command_interrupt_tb.sv
// self-checking bench of the host command and interrupt unit
// assumes host_model drives apb; events and ticks come from this bench
`timescale 1ns/10ps
`include "mp3_host_params.svh"

module mp3_host_command_interrupt_tb;
  logic        sys_clk_i, rst_n_i, psel, penable, pwrite, tick, obuf_empty;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq, ffwd, fbwd, hold, rden, mute;
  logic [7:0]  ratio, fskip, fdec, gain;
  logic [8:0]  evt;
  logic        ok_fb;
  logic [5:0]  pulse;
  logic [15:0] fa, rw, r;
  logic [32:0] exp_q[$];
  logic [7:0]  src_tab[8] = '{8'h20, 8'h40, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h01, 8'h02};
  logic [7:0]  cmd_tab[6] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h0E, 8'h03};
  int          mismatches, check_count, i, j, pc[6], ex[6];

  mp3_host_cmd #(.REPORT_SAMPLES(16'h0010)) uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .hdr_err_i(evt[0]), .addr_range_i(evt[1]),
    .fs_addr_req_i(evt[2]), .fs_addr_i(fa), .remap_done_i(evt[3]), .freq_evt_i(evt[4]),
    .freq_code_i(3'h0), .left_obuf_empty_i(evt[5]), .dump_end_i(evt[6]),
    .ibuf_state_i(evt[7]), .ibuf_clear_done_i(evt[8]), .rewound_sectors_i(rw),
    .obuf_empty_i(obuf_empty), .sample_tick_i(tick), .host_irq_line_o(irq),
    .start_tag_o(pulse[0]), .filesystem_decode_cmd_o(pulse[1]),
    .audio_decode_cmd_o(pulse[5]), .end_of_input_o(pulse[2]), .ibuf_clear_o(pulse[3]),
    .skip_directory_subtree_o(pulse[4]), .second_form_sectors_o(),
    .accept_video_extension_o(), .fast_fwd_o(ffwd), .fast_bwd_o(fbwd),
    .skip_ratio_o(ratio), .fwd_skip_o(fskip), .fwd_decode_o(fdec), .decode_hold_o(hold),
    .obuf_read_en_o(rden), .mute_samples_o(mute), .audio_gain_o(gain));

  host_model host (.sys_clk_i(sys_clk_i), .pready_i(pready), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // ------------------------------------------------------------
  // reporting and comparison
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic bad(input string m);
    mismatches++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    check_count++;
    if (act !== exp) bad($sformatf("port %h want %h", act, exp));
  endtask

  // read results are noted by the driver and judged here when they land
  always @(posedge sys_clk_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check_count++;
      if (exp_q.size() == 0) bad("read with no note");
      else if ({pslverr, prdata} !== exp_q[0]) bad($sformatf("read %h", prdata));
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    for (int k = 0; k < 6; k++) if (pulse[k] === 1'b1) pc[k]++;
  end

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // ------------------------------------------------------------
  // stimulus helpers
  // ------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic ok;
    host.xfer(1'b1, idx, {24'h00_0000, d}, ok);
    if (!ok) begin
      bad("bus timeout");
      complete_run();
    end
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic e);
    logic ok;
    exp_q.push_back({e, 24'h00_0000, d});
    host.xfer(1'b0, idx, 32'h0000_0000, ok);
    if (!ok) begin
      bad("bus timeout");
      complete_run();
    end
  endtask

  task automatic fire(input logic [8:0] m);
    @(posedge sys_clk_i);
    evt <= m;
    @(posedge sys_clk_i);
    evt <= 9'h000;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      tick <= 1'b1;
      @(posedge sys_clk_i);
      tick <= 1'b0;
    end
    idle(2);
  endtask

  task automatic wait_irq(input int n);
    int k;
    for (k = 0; k < n && irq !== 1'b1; k++) @(posedge sys_clk_i);
    if (irq !== 1'b1) begin
      bad("no interrupt");
      complete_run();
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    tick = 1'b0;
    obuf_empty = 1'b0;
    evt = 9'h000;
    r = 16'h0024;
    fa = 16'h0000;
    rw = 16'h0000;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    idle(2);
    chk(irq, 1'b0);
    chk(rden, 1'b1);
    chk(gain, 8'h00);
    rd(`IDX_INT_SOURCE, 8'h00, 1'b0);
    rd(`IDX_HOST_CMD, 8'h00, 1'b0);
    wr(`IDX_RESULT_LOW, 8'hAA);
    rd(`IDX_RESULT_LOW, 8'h00, 1'b0);
    rd(8'hC0, 8'h00, 1'b1);
    // fade up, pause, replay, soft mute
    ticks(5);
    chk(gain, 8'h05);
    wr(`IDX_HOST_CMD, `CMD_PAUSE);
    idle(2);
    chk({rden, mute}, 2'b01);
    ticks(3);
    chk(gain, 8'h02);
    wr(`IDX_HOST_CMD, `CMD_REPLAY);
    idle(2);
    chk({rden, mute}, 2'b10);
    ticks(2);
    chk(gain, 8'h04);
    wr(`IDX_HOST_CMD, `CMD_MUTE);
    idle(2);
    chk({rden, mute}, 2'b11);
    ticks(5);
    chk(gain, 8'h00);
    wr(`IDX_HOST_CMD, `CMD_MUTE_OFF);
    idle(2);
    chk(mute, 1'b0);
    rd(`IDX_MODE_STATUS, 8'h00, 1'b0);
    // mode levels and unknown codes
    r = nxt(r);
    wr(`IDX_PARAM_LOW, r[7:0]);
    wr(`IDX_PARAM_HIGH, r[15:8]);
    wr(`IDX_HOST_CMD, `CMD_FORM2);
    wr(`IDX_HOST_CMD, `CMD_VIDEO_OK);
    wr(`IDX_HOST_CMD, `CMD_FFWD);
    idle(2);
    chk({ffwd, fskip, fdec}, {1'b1, r[7:0], r[15:8]});
    rd(`IDX_MODE_STATUS, 8'h26, 1'b0);
    wr(`IDX_HOST_CMD, 8'h12);
    wr(`IDX_HOST_CMD, 8'h23);
    rd(`IDX_MODE_STATUS, 8'h26, 1'b0);
    rd(`IDX_PARAM_LOW, r[7:0], 1'b0);
    wr(`IDX_HOST_CMD, `CMD_REPLAY);
    rd(`IDX_MODE_STATUS, 8'h06, 1'b0);
    // each event input except clear done alone, then several at once
    for (i = 0; i < 8; i++) begin
      fa = nxt(fa ^ r);
      fire(9'(1 << i));
      idle(3);
      chk(irq, 1'b1);
      rd(`IDX_INT_SOURCE, src_tab[i], 1'b0);
      idle(2);
      chk(irq, 1'b0);
      if (i == 2) begin
        rd(`IDX_RESULT_LOW, fa[7:0], 1'b0);
        rd(`IDX_RESULT_HIGH, fa[15:8], 1'b0);
      end
    end
    fire(9'h04D);
    idle(2);
    rd(`IDX_INT_SOURCE, 8'h25, 1'b0);
    // hold after frequency report
    chk(hold, 1'b1);
    wr(`IDX_HOST_CMD, `CMD_CLK_DONE);
    idle(3);
    chk(hold, 1'b1);
    @(posedge sys_clk_i);
    obuf_empty <= 1'b1;
    idle(3);
    chk(hold, 1'b0);
    // fast backward with rewound count
    r = nxt(r);
    rw = nxt(r);
    host.fast_backward(r[7:0], ok_fb);
    chk(ok_fb, 1'b1);
    idle(2);
    chk({fbwd, ratio}, {1'b1, r[7:0]});
    fire(9'h100);
    wait_irq(10);
    rd(`IDX_INT_SOURCE, 8'h18, 1'b0);
    rd(`IDX_RESULT_LOW, rw[7:0], 1'b0);
    rd(`IDX_RESULT_HIGH, rw[15:8], 1'b0);
    // total time of 65611 sectors is 874 seconds
    wr(`IDX_PARAM_LOW, 8'h4B);
    wr(`IDX_PARAM_HIGH, 8'h00);
    wr(`IDX_PARAM_XTRA, 8'h01);
    wr(`IDX_HOST_CMD, `CMD_TOTAL);
    wait_irq(1500);
    rd(`IDX_INT_SOURCE, 8'h18, 1'b0);
    rd(`IDX_RESULT_LOW, 8'h6A, 1'b0);
    rd(`IDX_RESULT_HIGH, 8'h03, 1'b0);
    // one pulse per pulse command, audio start last
    ex = '{0, 0, 0, 1, 0, 0};
    for (i = 0; i < 6; i++) begin
      wr(`IDX_HOST_CMD, cmd_tab[i]);
      idle(3);
      ex[i]++;
      for (j = 0; j < 6; j++) chk(16'(pc[j]), 16'(ex[j]));
    end
    // elapsed time from sector 150, set after audio start since that zeroes it
    wr(`IDX_PARAM_LOW, 8'h96);
    wr(`IDX_HOST_CMD, `CMD_SET_TIME);
    idle(20);
    chk(irq, 1'b0);
    ticks(16);
    wait_irq(50);
    rd(`IDX_INT_SOURCE, 8'h1C, 1'b0);
    rd(`IDX_RESULT_LOW, 8'h02, 1'b0);
    rd(`IDX_RESULT_HIGH, 8'h00, 1'b0);
    idle(2);
    complete_run();
  end
endmodule // mp3_host_command_interrupt_tb

//--- logic/mp3_host_cmd.sv
// host command and interrupt unit of the audio decoder
// assumes apb master on sys_clk_i and event inputs synchronous, one-cycle pulses
//
// Function
// - every command register write is a new command
// - code 06 clears the input buffer
// - 09 is fast forward, 0A fast backward
// - buffer clear done raises source 110
// - rewound sector count goes to result bytes
// - periodic 111 interrupt carries elapsed seconds
// - code 11 sets elapsed time from sector
// - code 10 computes total time, source 110
// - one irq line, host reads source register
// - source bit7 zero, three unit fields
// - sector field 01 header, 10 range error
// - core 001 asks next filesystem sector address
// - core codes 010,011,101 remap, freq, left empty
// - memory field 01 dump end, 10 buffer state
// - codes 01,02,03 start tag, filesystem, audio
// - code 04 marks end of input
// - after freq report hold until 05 and empty
// - pause stops reading, mutes, fades out
// - replay clears pause, reads, fades in
// - soft mute reads but discards; 0C cancels
// - reading source register clears the interrupt
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "mp3_host_params.svh"

module mp3_host_cmd
  import mp3_host_pkg::*;
#(
  parameter logic [15:0] REPORT_SAMPLES = 16'h4000
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        hdr_err_i,
  input  wire logic        addr_range_i,
  input  wire logic        fs_addr_req_i,
  input  wire logic [15:0] fs_addr_i,
  input  wire logic        remap_done_i,
  input  wire logic        freq_evt_i,
  input  wire logic [2:0]  freq_code_i,
  input  wire logic        left_obuf_empty_i,
  input  wire logic        dump_end_i,
  input  wire logic        ibuf_state_i,
  input  wire logic        ibuf_clear_done_i,
  input  wire logic [15:0] rewound_sectors_i,
  input  wire logic        obuf_empty_i,
  input  wire logic        sample_tick_i,
  output logic             host_irq_line_o,
  output logic             start_tag_o,
  output logic             filesystem_decode_cmd_o,
  output logic             audio_decode_cmd_o,
  output logic             end_of_input_o,
  output logic             ibuf_clear_o,
  output logic             skip_directory_subtree_o,
  output logic             second_form_sectors_o,
  output logic             accept_video_extension_o,
  output logic             fast_fwd_o,
  output logic             fast_bwd_o,
  output logic [7:0]       skip_ratio_o,
  output logic [7:0]       fwd_skip_o,
  output logic [7:0]       fwd_decode_o,
  output logic             decode_hold_o,
  output logic             obuf_read_en_o,
  output logic             mute_samples_o,
  output logic [7:0]       audio_gain_o
);

  state_type q;
  state_type d;

  logic        setup;
  logic        access;
  logic        cmd_wr;
  logic        src_rd;
  logic [7:0]  cmd;
  logic [9:0]  widx;
  logic [2:0]  core_code;
  logic [15:0] core_pay;
  logic        core_ev;
  logic        ev_any;
  logic        div_done;
  logic        tick_rpt;
  logic [15:0] sps;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup  = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign widx   = paddr_i[11:2];
  assign cmd    = pwdata_i[7:0];
  assign cmd_wr = access & pwrite_i & (paddr_i == {2'b00, `IDX_HOST_CMD, 2'b00});
  assign src_rd = access & ~pwrite_i & (paddr_i == {2'b00, `IDX_INT_SOURCE, 2'b00});

  // zero wait states: read data is captured in the setup cycle
  assign pready_o  = 1'b1;
  assign prdata_o  = {24'h0000_00, q.rdata};
  assign pslverr_o = access & q.err;

  // ----------------------------------------------------------------
  // sample rate from the reported frequency code
  // ----------------------------------------------------------------
  always_comb begin
    case (q.fcode)
      3'h1:    sps = `SPS_48K;
      3'h2:    sps = `SPS_32K;
      3'h4:    sps = `SPS_22K05;
      3'h5:    sps = `SPS_24K;
      3'h6:    sps = `SPS_16K;
      default: sps = `SPS_44K1;
    endcase
  end

  assign div_done = (q.st != DIV_IDLE) && (q.dnum < `SECTORS_PER_SEC);
  assign tick_rpt = q.audio & ~q.pause & ~q.hold & sample_tick_i
                    & (q.rpt == REPORT_SAMPLES - 16'h0001);

  // ----------------------------------------------------------------
  // decode core events, one code at a time, clear and total-time divide completions first, time report last
  // ----------------------------------------------------------------
  always_comb begin
    core_ev   = 1'b1;
    core_code = `CORE_DONE;
    core_pay  = 16'h0000;
    if (q.ibclr & ibuf_clear_done_i) begin
      core_pay = rewound_sectors_i;
    end else if (div_done && q.st == DIV_TOT) begin
      core_pay = q.dquo;
    end else if (freq_evt_i) begin
      core_code = `CORE_FREQ;
      core_pay  = {13'h0000, freq_code_i};
    end else if (fs_addr_req_i) begin
      core_code = `CORE_FS_ADDR;
      core_pay  = fs_addr_i;
    end else if (remap_done_i) begin
      core_code = `CORE_REMAP;
    end else if (left_obuf_empty_i) begin
      core_code = `CORE_LOBUF;
    end else if (tick_rpt) begin
      core_code = `CORE_TIME;
      core_pay  = q.sec;
    end else begin
      core_ev   = 1'b0;
      core_code = 3'h0;
    end
  end

  assign ev_any = core_ev | hdr_err_i | addr_range_i | dump_end_i | ibuf_state_i;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d        = q;
    d.pulses = 8'h00;

    // read data and error are prepared in the setup cycle
    if (setup) begin
      d.err   = 1'b0;
      d.rdata = 8'h00;
      if (widx == {2'b00, `IDX_RESULT_LOW}) begin
        d.rdata = q.res[7:0];
      end else if (widx == {2'b00, `IDX_RESULT_HIGH}) begin
        d.rdata = q.res[15:8];
      end else if (widx == {2'b00, `IDX_INT_SOURCE}) begin
        d.rdata = q.src;
      end else if (widx == {2'b00, `IDX_HOST_CMD}) begin
        d.rdata = 8'h00;
      end else if (widx == {2'b00, `IDX_PARAM_LOW}) begin
        d.rdata = q.pl;
      end else if (widx == {2'b00, `IDX_PARAM_HIGH}) begin
        d.rdata = q.ph;
      end else if (widx == {2'b00, `IDX_PARAM_XTRA}) begin
        d.rdata = q.px;
      end else if (widx == {2'b00, `IDX_MODE_STATUS}) begin
        d.rdata = {q.hold, q.fbwd, q.ffwd, q.mute, q.pause, q.vidok, q.form2, q.audio};
      end else begin
        d.err = 1'b1;
      end
    end

    if (access & pwrite_i) begin
      if (widx == {2'b00, `IDX_PARAM_LOW}) begin
        d.pl = pwdata_i[7:0];
      end else if (widx == {2'b00, `IDX_PARAM_HIGH}) begin
        d.ph = pwdata_i[7:0];
      end else if (widx == {2'b00, `IDX_PARAM_XTRA}) begin
        d.px = pwdata_i[7:0];
      end
    end

    // read clears first so that an event in the same cycle survives
    if (src_rd) begin
      d.src = 8'h00;
    end
    if (hdr_err_i) begin
      d.src[`SRC_SECT_MSB:`SRC_SECT_LSB] = `SECT_HDR_ERR;
    end else if (addr_range_i) begin
      d.src[`SRC_SECT_MSB:`SRC_SECT_LSB] = `SECT_RANGE;
    end
    if (core_ev) begin
      d.src[`SRC_CORE_MSB:`SRC_CORE_LSB] = core_code;
      d.res = core_pay;
    end
    if (dump_end_i) begin
      d.src[`SRC_MEM_MSB:`SRC_MEM_LSB] = `MEM_DUMP_END;
    end else if (ibuf_state_i) begin
      d.src[`SRC_MEM_MSB:`SRC_MEM_LSB] = `MEM_IBUF_STATE;
    end
    d.src[7] = 1'b0;
    if (q.ibclr & ibuf_clear_done_i) begin
      d.ibclr = 1'b0;
    end

    // sampling frequency report holds decoding
    if (freq_evt_i) begin
      d.fcode = freq_code_i;
      d.hold  = 1'b1;
      d.clkok = 1'b0;
    end else if (q.hold & q.clkok & obuf_empty_i) begin
      d.hold = 1'b0;
    end

    // sector to seconds by repeated subtraction; slow but tiny
    if (q.st != DIV_IDLE) begin
      if (div_done) begin
        d.st = DIV_IDLE;
        if (q.st == DIV_SET) begin
          d.sec = q.dquo;
          d.smp = 16'h0000;
        end
      end else begin
        d.dnum = q.dnum - `SECTORS_PER_SEC;
        d.dquo = q.dquo + 16'h0001;
      end
    end

    // elapsed seconds and report timer
    if (q.audio & ~q.pause & ~q.hold & sample_tick_i & (q.st != DIV_SET)) begin
      d.rpt = tick_rpt ? 16'h0000 : q.rpt + 16'h0001;
      if (q.smp == sps - 16'h0001) begin
        d.smp = 16'h0000;
        d.sec = q.sec + 16'h0001;
      end else begin
        d.smp = q.smp + 16'h0001;
      end
    end

    // fade ramp, one step per output sample
    if (sample_tick_i) begin
      if (q.pause | q.mute) begin
        if (q.gain != 8'h00) begin
          d.gain = q.gain - 8'h01;
        end
      end else if (q.gain != `GAIN_MAX) begin
        d.gain = q.gain + 8'h01;
      end
    end

    // command interpreter
    if (cmd_wr) begin
      case (cmd)
        `CMD_TAG:       d.pulses[0] = 1'b1;
        `CMD_FS:        d.pulses[1] = 1'b1;
        `CMD_AUDIO: begin
          d.pulses[2] = 1'b1;
          d.audio     = 1'b1;
          d.sec       = 16'h0000;
          d.smp       = 16'h0000;
          d.rpt       = 16'h0000;
        end
        `CMD_END_INPUT: d.pulses[3] = 1'b1;
        `CMD_CLK_DONE:  d.clkok = q.hold;
        `CMD_IBUF_CLR: begin
          d.pulses[4] = 1'b1;
          d.ibclr     = 1'b1;
        end
        `CMD_PAUSE:     d.pause = 1'b1;
        `CMD_REPLAY: begin
          d.pause = 1'b0;
          d.ffwd  = 1'b0;
          d.fbwd  = 1'b0;
        end
        `CMD_FFWD: begin
          d.ffwd = 1'b1;
          d.fbwd = 1'b0;
        end
        `CMD_FBWD: begin
          d.fbwd = 1'b1;
          d.ffwd = 1'b0;
        end
        `CMD_MUTE:      d.mute = 1'b1;
        `CMD_MUTE_OFF:  d.mute = 1'b0;
        `CMD_FORM2:     d.form2 = 1'b1;
        `CMD_SKIP_DIR:  d.pulses[5] = 1'b1;
        `CMD_VIDEO_OK:  d.vidok = 1'b1;
        `CMD_TOTAL: begin
          if (q.st == DIV_IDLE) begin
            d.st   = DIV_TOT;
            d.dnum = {q.px[3:0], q.ph, q.pl};
            d.dquo = 16'h0000;
          end
        end
        `CMD_SET_TIME: begin
          if (q.st == DIV_IDLE) begin
            d.st   = DIV_SET;
            d.dnum = {4'h0, q.ph, q.pl};
            d.dquo = 16'h0000;
          end
        end
        default: d.pulses = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign host_irq_line_o          = |q.src;
  assign start_tag_o              = q.pulses[0];
  assign filesystem_decode_cmd_o  = q.pulses[1];
  assign audio_decode_cmd_o       = q.pulses[2];
  assign end_of_input_o           = q.pulses[3];
  assign ibuf_clear_o             = q.pulses[4];
  assign skip_directory_subtree_o = q.pulses[5];
  assign second_form_sectors_o    = q.form2;
  assign accept_video_extension_o = q.vidok;
  assign fast_fwd_o               = q.ffwd;
  assign fast_bwd_o               = q.fbwd;
  assign skip_ratio_o             = q.pl;
  assign fwd_skip_o               = q.pl;
  assign fwd_decode_o             = q.ph;
  assign decode_hold_o            = q.hold;
  assign obuf_read_en_o           = ~q.pause;
  assign mute_samples_o           = q.pause | q.mute;
  assign audio_gain_o             = q.gain;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_irq_hold;
    host_irq_line_o && !src_rd |=> host_irq_line_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without read");

  property p_read_clear;
    src_rd && !ev_any |=> !host_irq_line_o;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("source read did not clear");

  property p_bit7;
    !q.src[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("source bit 7 set");

  property p_clear_done;
    q.ibclr && ibuf_clear_done_i |=>
      q.src[4:2] == 3'b110 && q.res == $past(rewound_sectors_i) && host_irq_line_o;
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("clear done not reported");

  property p_freq_hold;
    freq_evt_i && !(q.ibclr && ibuf_clear_done_i) && !(div_done && q.st == DIV_TOT) |=>
      decode_hold_o && q.src[4:2] == 3'b011;
  endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("freq report did not hold");

  property p_pause;
    cmd_wr && cmd == 8'h07 |=> mute_samples_o && !obuf_read_en_o;
  endproperty
  a_pause: assert property (p_pause) else $error("pause not applied");

  property p_mute;
    cmd_wr && cmd == 8'h0B && !q.pause |=> mute_samples_o && obuf_read_en_o;
  endproperty
  a_mute: assert property (p_mute) else $error("soft mute wrong");

  property p_replay;
    cmd_wr && cmd == 8'h08 |=> !q.pause && obuf_read_en_o && !fast_bwd_o;
  endproperty
  a_replay: assert property (p_replay) else $error("replay did not resume");

  property p_audio;
    cmd_wr && cmd == 8'h03 |=> audio_decode_cmd_o ##1 !audio_decode_cmd_o;
  endproperty
  a_audio: assert property (p_audio) else $error("audio start pulse wrong");

  property p_total;
    cmd_wr && cmd == 8'h10 && q.st == DIV_IDLE |=> q.st == DIV_TOT;
  endproperty
  a_total: assert property (p_total) else $error("total time not started");

endmodule // mp3_host_cmd

//--- logic/mp3_host_params.svh
// offsets, field positions, command codes and counts for the host command unit
// assumes a 32-bit apb slave in which each register sits in one aligned word
`ifndef MP3_HOST_PARAMS_SVH
`define MP3_HOST_PARAMS_SVH
// register indices as printed, byte address is four times the index
`define IDX_RESULT_LOW   8'h01
`define IDX_RESULT_HIGH  8'h02
`define IDX_INT_SOURCE   8'h51
`define IDX_HOST_CMD     8'h80
`define IDX_PARAM_LOW    8'h81
`define IDX_PARAM_HIGH   8'h82
`define IDX_PARAM_XTRA   8'h83
`define IDX_MODE_STATUS  8'h90
// interrupt source fields
`define SRC_SECT_MSB     6
`define SRC_SECT_LSB     5
`define SRC_CORE_MSB     4
`define SRC_CORE_LSB     2
`define SRC_MEM_MSB      1
`define SRC_MEM_LSB      0
`define SECT_HDR_ERR     2'h1
`define SECT_RANGE       2'h2
`define CORE_FS_ADDR     3'h1
`define CORE_REMAP       3'h2
`define CORE_FREQ        3'h3
`define CORE_LOBUF       3'h5
`define CORE_DONE        3'h6
`define CORE_TIME        3'h7
`define MEM_DUMP_END     2'h1
`define MEM_IBUF_STATE   2'h2
// command codes
`define CMD_TAG          8'h01
`define CMD_FS           8'h02
`define CMD_AUDIO        8'h03
`define CMD_END_INPUT    8'h04
`define CMD_CLK_DONE     8'h05
`define CMD_IBUF_CLR     8'h06
`define CMD_PAUSE        8'h07
`define CMD_REPLAY       8'h08
`define CMD_FFWD         8'h09
`define CMD_FBWD         8'h0A
`define CMD_MUTE         8'h0B
`define CMD_MUTE_OFF     8'h0C
`define CMD_FORM2        8'h0D
`define CMD_SKIP_DIR     8'h0E
`define CMD_VIDEO_OK     8'h0F
`define CMD_TOTAL        8'h10
`define CMD_SET_TIME     8'h11
// counts
`define SECTORS_PER_SEC  20'h0_004B
`define GAIN_MAX         8'hFF
`define SPS_44K1         16'hAC44
`define SPS_48K          16'hBB80
`define SPS_32K          16'h7D00
`define SPS_22K05        16'h5622
`define SPS_24K          16'h5DC0
`define SPS_16K          16'h3E80
`endif

//--- logic/mp3_host_pkg.sv
// types shared by the host command unit
// assumes mp3_host_params.svh holds all numeric constants
package mp3_host_pkg;
  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_SET  = 2'b01,
    DIV_TOT  = 2'b10
  } div_state_type;

  typedef struct packed {
    logic [7:0]    src;
    logic [15:0]   res;
    logic [7:0]    rdata;
    logic          err;
    logic [7:0]    pl;
    logic [7:0]    ph;
    logic [7:0]    px;
    logic          pause;
    logic          mute;
    logic          form2;
    logic          vidok;
    logic          ffwd;
    logic          fbwd;
    logic          audio;
    logic          hold;
    logic          clkok;
    logic          ibclr;
    logic [2:0]    fcode;
    div_state_type st;
    logic [19:0]   dnum;
    logic [15:0]   dquo;
    logic [15:0]   sec;
    logic [15:0]   smp;
    logic [15:0]   rpt;
    logic [7:0]    gain;
    logic [7:0]    pulses;
  } state_type;
endpackage
